// ==== pkg/bja_pkg.sv ====
// Package for the byte ALU and jump datapath: opcodes, flag positions,
// cycle counts and widths. Assumes a single 200 MHz core clock.
package bja_pkg;

  localparam int DATA_W = 8;
  localparam int WORD_W = 16;
  localparam int PC_W   = 16;
  localparam int OFFS_W = 12;

  // Status flag positions in the flag vector
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;

  localparam logic [5:0]      FLAGS_RST = 6'h00;
  localparam logic [PC_W-1:0] PC_RST    = 16'h0000;

  // Cycle counts per operation class
  localparam logic [1:0] CYC_BYTE = 2'h1;
  localparam logic [1:0] CYC_WORD = 2'h2;
  localparam logic [1:0] CYC_JUMP = 2'h2;
  localparam logic [1:0] CYC_CALL = 2'h3;

  typedef enum logic [4:0] {
    OP_ADD, OP_ADD_CARRY, OP_WORD_PLUS_IMMEDIATE, OP_SUB, OP_MINUS_CONSTANT,
    OP_MINUS_WITH_BORROW, OP_MINUS_CONSTANT_BORROW, OP_WORD_MINUS_IMMEDIATE,
    OP_AND, OP_AND_IMMEDIATE, OP_OR, OP_OR_IMMEDIATE, OP_XOR_REGISTERS,
    OP_SET_BITS_MASK, OP_CLEAR_BITS_MASK, OP_ZERO_SIGN_TEST,
    OP_BITWISE_INVERT, OP_TWOS_COMPLEMENT, OP_INC, OP_DEC,
    OP_ZERO_REGISTER, OP_ALL_ONES_REGISTER,
    OP_RELATIVE_JUMP, OP_POINTER_JUMP, OP_RELATIVE_CALL, OP_NOP
  } bja_op_t;

endpackage

// ==== src/bja_word_unit.sv ====
// Word add/subtract of an immediate on a register pair, with flags.
// Assumes the caller holds the operands steady while the result is used.
`timescale 1ns/1ps
module bja_word_unit
  import bja_pkg::*;
(
  // Operands
  input  wire logic [WORD_W-1:0] pair_val,
  input  wire logic [5:0]        imm_val,
  input  wire logic              do_sub,
  // Result
  output logic      [WORD_W-1:0] res,
  output logic                   f_c,
  output logic                   f_z,
  output logic                   f_n,
  output logic                   f_v,
  output logic                   f_s
);

  logic [WORD_W:0] ext;

  assign ext = do_sub ? ({1'b0, pair_val} - {11'h000, imm_val})
                      : ({1'b0, pair_val} + {11'h000, imm_val});
  assign res = ext[WORD_W-1:0];
  assign f_c = do_sub ? (res[15] & ~pair_val[15]) : (~res[15] & pair_val[15]);
  assign f_z = (res == 16'h0000);
  assign f_n = res[15];
  assign f_v = do_sub ? (pair_val[15] & ~res[15]) : (~pair_val[15] & res[15]);
  assign f_s = f_n ^ f_v;

endmodule

// ==== src/bja_datapath.sv ====
// Byte ALU and program counter datapath of an 8-bit core.
// Assumes the decoder holds op/operands while busy is high and issues
// a start pulse only when busy is low; the register file takes result
// on res_we.
`timescale 1ns/1ps
module bja_datapath
  import bja_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Request from the decoder
  input  wire logic              start,
  input  wire bja_op_t           op,
  input  wire logic [DATA_W-1:0] rd_val,
  input  wire logic [DATA_W-1:0] rr_val,
  input  wire logic [DATA_W-1:0] k_val,
  input  wire logic [WORD_W-1:0] pair_val,
  input  wire logic [WORD_W-1:0] z_ptr,
  input  wire logic [OFFS_W-1:0] rel_offs,
  // Results
  output logic                   busy,
  output logic                   res_we,
  output logic      [DATA_W-1:0] res_byte,
  output logic                   word_we,
  output logic      [WORD_W-1:0] res_word,
  output logic                   push_we,
  output logic      [PC_W-1:0]   push_addr,
  output logic      [5:0]        flags,
  output logic      [PC_W-1:0]   pc
);

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT} bja_state_t;

  //////////////////////////////////////////////////////////////////////////////
  // Byte arithmetic helpers

  function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b,
                                      input logic ci);
    add9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
  endfunction

  function automatic logic [8:0] sub9(input logic [7:0] a, input logic [7:0] b,
                                      input logic bi);
    sub9 = {1'b0, a} - {1'b0, b} - {8'h00, bi};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Operand selection and results

  wire logic       cin      = flags[FLG_C];
  wire logic       imm_op   = (op == OP_MINUS_CONSTANT) || (op == OP_MINUS_CONSTANT_BORROW)
                              || (op == OP_AND_IMMEDIATE) || (op == OP_OR_IMMEDIATE)
                              || (op == OP_SET_BITS_MASK) || (op == OP_CLEAR_BITS_MASK);
  wire logic [7:0] opb      = imm_op ? k_val : rr_val;
  wire logic [8:0] add_ext  = add9(rd_val, rr_val,
                                   (op == OP_ADD_CARRY) & cin);
  wire logic       sub_brw  = ((op == OP_MINUS_WITH_BORROW)
                               || (op == OP_MINUS_CONSTANT_BORROW)) & cin;
  wire logic [8:0] sub_ext  = sub9(rd_val, opb, sub_brw);
  wire logic [8:0] cpl_ext  = sub9(8'h00, rd_val, 1'b0);
  wire logic [7:0] and_res  = rd_val & opb;
  wire logic [7:0] or_res   = rd_val | opb;
  wire logic [7:0] xor_res  = rd_val ^ rr_val;
  wire logic [7:0] clr_res  = rd_val & (8'hFF - k_val);
  wire logic [7:0] self_res = rd_val & rd_val;
  wire logic [7:0] inc_res  = rd_val + 8'h01;
  wire logic [7:0] dec_res  = rd_val - 8'h01;

  wire logic [WORD_W-1:0] w_res;
  logic w_c, w_z, w_n, w_v, w_s;

  bja_word_unit u_word (
    .pair_val (pair_val),
    .imm_val  (k_val[5:0]),
    .do_sub   (op == OP_WORD_MINUS_IMMEDIATE),
    .res      (w_res),
    .f_c      (w_c),
    .f_z      (w_z),
    .f_n      (w_n),
    .f_v      (w_v),
    .f_s      (w_s)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Byte result and flag update

  logic [7:0] b_res;
  logic [5:0] f_nxt;
  logic       b_we;

  always_comb begin
    b_res = 8'h00;
    b_we  = 1'b1;
    f_nxt = flags;
    case (op)
      OP_ADD, OP_ADD_CARRY: begin
        b_res = add_ext[7:0];
        f_nxt[FLG_C] = add_ext[8];
        f_nxt[FLG_H] = (rd_val[3] & rr_val[3]) | (rr_val[3] & ~b_res[3])
                       | (~b_res[3] & rd_val[3]);
        f_nxt[FLG_V] = (rd_val[7] & rr_val[7] & ~b_res[7])
                       | (~rd_val[7] & ~rr_val[7] & b_res[7]);
      end
      OP_SUB, OP_MINUS_CONSTANT, OP_MINUS_WITH_BORROW, OP_MINUS_CONSTANT_BORROW: begin
        b_res = sub_ext[7:0];
        f_nxt[FLG_C] = sub_ext[8];
        f_nxt[FLG_H] = (~rd_val[3] & opb[3]) | (opb[3] & b_res[3])
                       | (b_res[3] & ~rd_val[3]);
        f_nxt[FLG_V] = (rd_val[7] & ~opb[7] & ~b_res[7])
                       | (~rd_val[7] & opb[7] & b_res[7]);
      end
      OP_AND, OP_AND_IMMEDIATE, OP_ZERO_SIGN_TEST: begin
        b_res = (op == OP_ZERO_SIGN_TEST) ? self_res : and_res;
        f_nxt[FLG_V] = 1'b0;
      end
      OP_OR, OP_OR_IMMEDIATE, OP_SET_BITS_MASK: begin
        b_res = or_res;
        f_nxt[FLG_V] = 1'b0;
      end
      OP_XOR_REGISTERS: begin
        b_res = xor_res;
        f_nxt[FLG_V] = 1'b0;
      end
      OP_CLEAR_BITS_MASK: begin
        b_res = clr_res;
        f_nxt[FLG_V] = 1'b0;
      end
      OP_BITWISE_INVERT: begin
        b_res = 8'hFF - rd_val;
        f_nxt[FLG_C] = 1'b1;
        f_nxt[FLG_V] = 1'b0;
      end
      OP_TWOS_COMPLEMENT: begin
        b_res = cpl_ext[7:0];
        f_nxt[FLG_C] = (b_res != 8'h00);
        f_nxt[FLG_H] = b_res[3] | rd_val[3];
        f_nxt[FLG_V] = (b_res == 8'h80);
      end
      OP_INC: begin
        b_res = inc_res;
        f_nxt[FLG_V] = (rd_val == 8'h7F);
      end
      OP_DEC: begin
        b_res = dec_res;
        f_nxt[FLG_V] = (rd_val == 8'h80);
      end
      OP_ZERO_REGISTER: begin
        b_res = 8'h00;
        f_nxt[FLG_V] = 1'b0;
      end
      OP_ALL_ONES_REGISTER: begin
        b_res = 8'hFF; // flags untouched
      end
      OP_WORD_PLUS_IMMEDIATE, OP_WORD_MINUS_IMMEDIATE: begin
        b_we = 1'b0;
        f_nxt[FLG_C] = w_c;
        f_nxt[FLG_Z] = w_z;
        f_nxt[FLG_N] = w_n;
        f_nxt[FLG_V] = w_v;
        f_nxt[FLG_S] = w_s;
      end
      default: begin
        b_we = 1'b0; // jumps and idle leave flags alone
      end
    endcase
    if (b_we && (op != OP_ALL_ONES_REGISTER)) begin
      f_nxt[FLG_Z] = (b_res == 8'h00);
      f_nxt[FLG_N] = b_res[7];
      f_nxt[FLG_S] = b_res[7] ^ f_nxt[FLG_V];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencing of multi-cycle operations

  wire logic is_word = (op == OP_WORD_PLUS_IMMEDIATE) || (op == OP_WORD_MINUS_IMMEDIATE);
  wire logic is_jmp  = (op == OP_RELATIVE_JUMP) || (op == OP_POINTER_JUMP);
  wire logic is_call = (op == OP_RELATIVE_CALL);
  wire logic [1:0] cyc_need = is_word ? CYC_WORD : is_jmp ? CYC_JUMP
                              : is_call ? CYC_CALL : CYC_BYTE;
  wire logic [PC_W-1:0] rel_tgt = pc + {{(PC_W-OFFS_W){rel_offs[OFFS_W-1]}}, rel_offs}
                                  + 16'h0001;
  wire logic [PC_W-1:0] pc_tgt  = (op == OP_POINTER_JUMP) ? z_ptr : rel_tgt;

  bja_state_t state_r, state_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  wire logic  accept = start && (state_r == ST_IDLE);
  wire logic  finish = (state_r == ST_IDLE) ? (accept && (cyc_need == CYC_BYTE))
                                            : (cnt_r == 2'h1);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ST_IDLE: begin
        if (accept && (cyc_need != CYC_BYTE)) begin
          state_nxt = ST_WAIT;
          cnt_nxt   = cyc_need - 2'h1;
        end
      end
      ST_WAIT: begin
        cnt_nxt = cnt_r - 2'h1;
        if (cnt_r == 2'h1) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  assign busy = (state_r != ST_IDLE);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cnt_r   <= 2'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Result registers: updated when the operation completes

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flags     <= FLAGS_RST;
      pc        <= PC_RST;
      res_byte  <= 8'h00;
      res_word  <= 16'h0000;
      res_we    <= 1'b0;
      word_we   <= 1'b0;
      push_we   <= 1'b0;
      push_addr <= 16'h0000;
    end else begin
      res_we  <= finish && b_we;
      word_we <= finish && is_word;
      push_we <= finish && is_call;
      if (finish) begin
        flags    <= f_nxt;
        res_byte <= b_res;
        res_word <= w_res;
        if (is_jmp || is_call) begin
          pc <= pc_tgt;
        end
        if (is_call) begin
          push_addr <= pc + 16'h0001;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  a_byte_one_clock: assert property (@(posedge clk_sys) disable iff (rst)
    accept && (op == OP_ADD) |=> res_we && !busy)
    else $error("byte op did not finish in one clock");

  sequence s_word_go;
    accept && is_word;
  endsequence
  a_word_two_clock: assert property (@(posedge clk_sys) disable iff (rst)
    s_word_go |=> busy && !word_we ##1 word_we && !busy)
    else $error("word op not two clocks");

  a_word_sub_val: assert property (@(posedge clk_sys) disable iff (rst)
    (s_word_go and (op == OP_WORD_MINUS_IMMEDIATE)) |=> ##1
    res_word == $past(pair_val, 2) - {10'h000, $past(k_val[5:0], 2)})
    else $error("word subtract wrong");

  a_sub_value: assert property (@(posedge clk_sys) disable iff (rst)
    accept && (op == OP_MINUS_WITH_BORROW) |=>
    res_byte == $past(rd_val) - $past(rr_val) - {7'h00, $past(flags[FLG_C])})
    else $error("borrow subtract wrong");

  a_logic_keep_c: assert property (@(posedge clk_sys) disable iff (rst)
    accept && (op == OP_AND_IMMEDIATE || op == OP_OR || op == OP_XOR_REGISTERS)
    |=> flags[FLG_C] == $past(flags[FLG_C]) && flags[FLG_H] == $past(flags[FLG_H])
        && !flags[FLG_V])
    else $error("logic op touched carry");

  a_clr_mask_val: assert property (@(posedge clk_sys) disable iff (rst)
    accept && (op == OP_CLEAR_BITS_MASK) |=>
    res_byte == ($past(rd_val) & ~$past(k_val)))
    else $error("clear bits wrong");

  a_test_zero: assert property (@(posedge clk_sys) disable iff (rst)
    accept && (op == OP_ZERO_SIGN_TEST) |=>
    flags[FLG_Z] == ($past(rd_val) == 8'h00) && res_byte == $past(rd_val))
    else $error("test flags wrong");

  a_ptr_jump: assert property (@(posedge clk_sys) disable iff (rst)
    accept && (op == OP_POINTER_JUMP) |=> ##1 pc == $past(z_ptr, 2)
    && flags == $past(flags, 2))
    else $error("pointer jump wrong");

  a_call_three: assert property (@(posedge clk_sys) disable iff (rst)
    accept && is_call |=> !push_we [*2] ##1 push_we)
    else $error("call not three clocks");

  a_ones_noflag: assert property (@(posedge clk_sys) disable iff (rst)
    accept && (op == OP_ALL_ONES_REGISTER) |=> flags == $past(flags)
    && res_byte == 8'hFF)
    else $error("set ones changed flags");

endmodule

// ==== tb/bja_regfile_model.sv ====
// Register file side of the datapath: takes every write and push it sees.
// Assumes write strobes are one-cycle pulses on clk_sys.
`timescale 1ns/1ps
module bja_regfile_model
  import bja_pkg::*;
(
  // Clock
  input  wire logic              clk_sys,
  // Writes from the datapath
  input  wire logic              res_we,
  input  wire logic [DATA_W-1:0] res_byte,
  input  wire logic              word_we,
  input  wire logic [WORD_W-1:0] res_word,
  input  wire logic              push_we,
  input  wire logic [PC_W-1:0]   push_addr,
  // Counts and last stacked address
  output int                     n_byte,
  output int                     n_word,
  output int                     n_push,
  output logic      [PC_W-1:0]   stack_top,
  // Last values written into the destination and the pair
  output logic      [DATA_W-1:0] last_byte,
  output logic      [WORD_W-1:0] last_word
);

  initial begin
    n_byte = 0;
    n_word = 0;
    n_push = 0;
    stack_top = 16'h0000;
    last_byte = 8'h00;
    last_word = 16'h0000;
  end

  always @(posedge clk_sys) begin
    if (res_we) begin
      last_byte <= res_byte;
      n_byte <= n_byte + 1;
    end
    if (word_we) begin
      last_word <= res_word;
      n_word <= n_word + 1;
    end
    if (push_we) begin
      stack_top <= push_addr;
      n_push <= n_push + 1;
    end
  end
endmodule

// ==== tb/bja_datapath_tb.sv ====
// Self-checking bench for the byte ALU and jump datapath.
// Assumes the hand-over latencies: byte 1, word 2, jump 2, call 3 clocks.
`timescale 1ns/1ps
module bja_datapath_tb
  import bja_pkg::*;
;
  logic clk_sys, rst, start, busy, res_we, word_we, push_we;
  bja_op_t op;
  logic [7:0]  rd_val, rr_val, k_val, res_byte, er, last_byte;
  logic [15:0] pair_val, z_ptr, res_word, push_addr, pc, stack_top, last_word;
  logic [11:0] rel_offs;
  logic [5:0]  flags, ef;
  int          n_errors, compares, n_byte, n_word, n_push;
  logic        pend;
  bja_op_t bops[19] = '{OP_ADD, OP_ADD_CARRY, OP_SUB, OP_MINUS_CONSTANT, OP_MINUS_WITH_BORROW,
    OP_MINUS_CONSTANT_BORROW, OP_AND, OP_AND_IMMEDIATE, OP_OR, OP_OR_IMMEDIATE,
    OP_XOR_REGISTERS, OP_SET_BITS_MASK, OP_CLEAR_BITS_MASK, OP_ZERO_SIGN_TEST,
    OP_BITWISE_INVERT, OP_TWOS_COMPLEMENT, OP_INC, OP_DEC, OP_ZERO_REGISTER};
  logic [7:0] va[6] = '{8'h3C, 8'h7F, 8'hF0, 8'h80, 8'hFF, 8'h0F};
  logic [7:0] vb[6] = '{8'hC5, 8'h01, 8'h0F, 8'h01, 8'h01, 8'h80};
  logic [7:0] vk[6] = '{8'h0F, 8'h81, 8'h10, 8'h70, 8'h01, 8'h08};

  bja_datapath dut (.clk_sys(clk_sys), .rst(rst), .start(start), .op(op), .rd_val(rd_val),
    .rr_val(rr_val), .k_val(k_val), .pair_val(pair_val), .z_ptr(z_ptr), .rel_offs(rel_offs),
    .busy(busy), .res_we(res_we), .res_byte(res_byte), .word_we(word_we),
    .res_word(res_word), .push_we(push_we), .push_addr(push_addr), .flags(flags), .pc(pc));

  bja_regfile_model far (.clk_sys(clk_sys), .res_we(res_we), .res_byte(res_byte),
    .word_we(word_we), .res_word(res_word), .push_we(push_we), .push_addr(push_addr),
    .n_byte(n_byte), .n_word(n_word), .n_push(n_push), .stack_top(stack_top),
    .last_byte(last_byte), .last_word(last_word));

  always #2.5 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [13:0] exp_byte(bja_op_t o, logic [7:0] a, b, k, logic [5:0] f);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] x, y, r;
    logic [5:0] n;
    logic c, sb, v, lg;
    sb = o inside {OP_SUB, OP_MINUS_CONSTANT, OP_MINUS_WITH_BORROW, OP_MINUS_CONSTANT_BORROW,
      OP_TWOS_COMPLEMENT, OP_DEC};
    lg = o inside {OP_AND, OP_AND_IMMEDIATE, OP_OR, OP_OR_IMMEDIATE, OP_XOR_REGISTERS,
      OP_SET_BITS_MASK, OP_CLEAR_BITS_MASK, OP_ZERO_SIGN_TEST, OP_ZERO_REGISTER,
      OP_BITWISE_INVERT};
    x = (o == OP_TWOS_COMPLEMENT) ? 8'h00 : a;
    y = (o inside {OP_MINUS_CONSTANT, OP_MINUS_CONSTANT_BORROW, OP_AND_IMMEDIATE,
      OP_OR_IMMEDIATE, OP_SET_BITS_MASK, OP_CLEAR_BITS_MASK}) ? k : b;
    if (o == OP_TWOS_COMPLEMENT) y = a;
    if (o inside {OP_INC, OP_DEC}) y = 8'h01;
    c = (o inside {OP_ADD_CARRY, OP_MINUS_WITH_BORROW, OP_MINUS_CONSTANT_BORROW}) && f[FLG_C];
    s = sb ? {1'b0, x} - {1'b0, y} - c : {1'b0, x} + {1'b0, y} + c;
    h = sb ? {1'b0, x[3:0]} - {1'b0, y[3:0]} - c : {1'b0, x[3:0]} + {1'b0, y[3:0]} + c;
    r = s[7:0];
    v = sb ? (x[7] & ~y[7] & ~r[7]) | (~x[7] & y[7] & r[7])
           : (x[7] & y[7] & ~r[7]) | (~x[7] & ~y[7] & r[7]);
    case (o)
      OP_AND, OP_AND_IMMEDIATE: r = a & y;
      OP_OR, OP_OR_IMMEDIATE, OP_SET_BITS_MASK: r = a | y;
      OP_XOR_REGISTERS: r = a ^ y;
      OP_CLEAR_BITS_MASK: r = a & (8'hFF - y);
      OP_ZERO_SIGN_TEST: r = a & a;
      OP_ZERO_REGISTER: r = a ^ a;
      OP_BITWISE_INVERT: r = 8'hFF - a;
      default: ;
    endcase
    n = f;
    n[FLG_C] = (o == OP_BITWISE_INVERT) ? 1'b1
             : (lg || o inside {OP_INC, OP_DEC}) ? f[FLG_C] : s[8];
    n[FLG_H] = (lg || o inside {OP_INC, OP_DEC}) ? f[FLG_H] : h[4];
    n[FLG_V] = lg ? 1'b0 : v;
    n[FLG_Z] = (r == 8'h00);
    n[FLG_N] = r[7];
    n[FLG_S] = r[7] ^ n[FLG_V];
    return {n, r};
  endfunction

  function automatic logic [21:0] exp_word(logic sb, logic [15:0] p, logic [5:0] k, logic [5:0] f);
    logic [16:0] s;
    logic [5:0]  n;
    s = sb ? {1'b0, p} - {11'h000, k} : {1'b0, p} + {11'h000, k};
    n = f;
    n[FLG_C] = s[16];
    n[FLG_Z] = (s[15:0] == 16'h0000);
    n[FLG_N] = s[15];
    n[FLG_V] = sb ? p[15] & ~s[15] : ~p[15] & s[15];
    n[FLG_S] = s[15] ^ n[FLG_V];
    return {n, s[15:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_byte;
    chk("res_we", 16'h0001, res_we);
    chk("res_byte", er, res_byte);
    chk("flags", ef, flags);
  endtask

  task automatic word_op(input bja_op_t o, input logic [15:0] p, input logic [5:0] k);
    logic [15:0] ew;
    @(negedge clk_sys);
    start = 1'b1;
    op = o;
    pair_val = p;
    k_val = {2'b11, k};
    {ef, ew} = exp_word(o == OP_WORD_MINUS_IMMEDIATE, p, k, ef);
    @(negedge clk_sys);
    start = 1'b0;
    chk("busy", 16'h0001, busy);
    chk("word_we", 16'h0000, word_we);
    @(negedge clk_sys);
    chk("busy", 16'h0000, busy);
    chk("word_we", 16'h0001, word_we);
    chk("res_word", ew, res_word);
    chk("flags", ef, flags);
  endtask

  task automatic ctl_op(input bja_op_t o, input logic [15:0] z, input logic [11:0] d,
                        input int n, input logic [15:0] epc, input logic [15:0] eret);
    @(negedge clk_sys);
    start = 1'b1;
    op = o;
    z_ptr = z;
    rel_offs = d;
    for (int i = 1; i < n; i++) begin
      @(negedge clk_sys);
      chk("busy", 16'h0001, busy);
      start = (o == OP_RELATIVE_CALL) && (i == 1);
    end
    @(negedge clk_sys);
    start = 1'b0;
    chk("busy", 16'h0000, busy);
    chk("pc", epc, pc);
    chk("flags", ef, flags);
    chk("push_we", {15'h0000, o == OP_RELATIVE_CALL}, push_we);
    if (o == OP_RELATIVE_CALL) chk("push_addr", eret, push_addr);
  endtask

  task automatic stop_test;
    if (n_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_errors++;
    stop_test();
  end

  initial begin
    {clk_sys, start, pend, n_errors, compares} = '0;
    rst = 1'b1;
    op = OP_NOP;
    {rd_val, rr_val, k_val, pair_val, z_ptr, rel_offs} = '0;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    chk("flags", 16'h0000, flags);
    chk("pc", 16'h0000, pc);
    chk("busy", 16'h0000, busy);
    ef = FLAGS_RST;
    // Every byte op except OP_ALL_ONES_REGISTER back to back, flags chained from one op to the next
    foreach (va[i]) foreach (bops[j]) begin
      @(negedge clk_sys);
      if (pend) chk_byte();
      start = 1'b1;
      op = bops[j];
      {rd_val, rr_val, k_val} = {va[i], vb[i], vk[i]};
      {ef, er} = exp_byte(bops[j], va[i], vb[i], vk[i], ef);
      pend = 1'b1;
    end
    @(negedge clk_sys);
    chk_byte();
    op = OP_ALL_ONES_REGISTER;
    er = 8'hFF;
    @(negedge clk_sys);
    start = 1'b0;
    chk_byte();
    word_op(OP_WORD_PLUS_IMMEDIATE, 16'hFFC0, 6'h3F);
    word_op(OP_WORD_PLUS_IMMEDIATE, 16'h7FFF, 6'h01);
    word_op(OP_WORD_PLUS_IMMEDIATE, 16'hFFFF, 6'h01);
    word_op(OP_WORD_MINUS_IMMEDIATE, 16'h0000, 6'h01);
    word_op(OP_WORD_MINUS_IMMEDIATE, 16'h8000, 6'h01);
    word_op(OP_WORD_MINUS_IMMEDIATE, 16'h0005, 6'h05);
    ctl_op(OP_POINTER_JUMP, 16'h1234, 12'h000, 2, 16'h1234, 16'h0000);
    ctl_op(OP_RELATIVE_JUMP, 16'h0000, 12'hFFF, 2, 16'h1234, 16'h0000);
    ctl_op(OP_RELATIVE_JUMP, 16'h0000, 12'h7FF, 2, 16'h1A34, 16'h0000);
    ctl_op(OP_RELATIVE_CALL, 16'h0000, 12'h800, 3, 16'h1235, 16'h1A35);
    ctl_op(OP_POINTER_JUMP, 16'hFFFF, 12'h000, 2, 16'hFFFF, 16'h0000);
    ctl_op(OP_RELATIVE_JUMP, 16'h0000, 12'h001, 2, 16'h0001, 16'h0000);
    @(negedge clk_sys);
    chk("byte writes", 16'd115, n_byte[15:0]);
    chk("word writes", 16'd6, n_word[15:0]);
    chk("pushes", 16'd1, n_push[15:0]);
    chk("stack top", 16'h1A35, stack_top);
    chk("last byte", 16'h00FF, {8'h00, last_byte});
    chk("last word", 16'h0000, last_word);
    stop_test();
  end
endmodule
